/* tcs_base_mem.sv */
// Baseline store, one word per electrode, registered read.
// Assumes a write and a read of one address never share a cycle.
`timescale 1ns/1ps
module tcs_base_mem #(
  parameter int W = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem_ff [DEPTH];
  logic [W-1:0] rdata_ff;

  // Write port and registered read port
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
    rdata_ff <= mem_ff[i_raddr];
  end

  assign o_rdata = rdata_ff;
endmodule // tcs_base_mem

/* tcs_click_gen.sv */
// Key-click square wave generator for a piezo sounder.
// Assumes a one-cycle millisecond pulse from the parent.
`timescale 1ns/1ps
`include "tcs_defines.svh"
module tcs_click_gen import tcs_pkg::*; #(
  parameter logic [15:0] P_HALF_LO = 16'd12500,
  parameter logic [15:0] P_HALF_HI = 16'd6250
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_ms_p,
  input wire logic i_enable,
  input wire logic i_long,
  input wire logic i_high,
  output logic o_sound
);
  tcs_click_st_type st_ff, nxt_st;
  logic [15:0] half_c;

  assign half_c = st_ff.hi ? P_HALF_HI : P_HALF_LO;

  // Tone toggling, click length and enable gate
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.act) begin
      if (st_ff.ph == half_c - 16'h0001) begin
        nxt_st.ph = 16'h0000;
        nxt_st.out = ~st_ff.out;
      end else begin
        nxt_st.ph = st_ff.ph + 16'h0001;
      end
      if (i_ms_p) begin
        if (st_ff.ms_left == 5'h01) begin
          nxt_st.act = 1'b0;
          nxt_st.out = 1'b0;
        end else begin
          nxt_st.ms_left = st_ff.ms_left - 5'h01;
        end
      end
    end
    if (i_start) begin
      nxt_st.act = 1'b1;
      nxt_st.hi = i_high;
      nxt_st.ph = 16'h0000;
      nxt_st.out = 1'b1;
      nxt_st.ms_left = i_long ? `TCS_CLICK_LONG_MS
                              : `TCS_CLICK_SHORT_MS;
    end
    if (!i_enable) begin
      nxt_st.act = 1'b0;
      nxt_st.out = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sound = st_ff.out;

  a_snd_gate: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_enable |=> !o_sound) else $error("sounder active while disabled");
  a_click_len: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_start && i_enable |=> st_ff.ms_left == ($past(i_long) ?
      `TCS_CLICK_LONG_MS : `TCS_CLICK_SHORT_MS))
    else $error("click length wrong");
  a_tone_half: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    st_ff.act && $past(st_ff.act) && $changed(st_ff.out) && i_enable
      |-> $past(st_ff.ph) == $past(half_c) - 16'h0001)
    else $error("tone half period wrong");
endmodule // tcs_click_gen

/* tcs_defines.svh */
// Constants of the touch calibration and key-click block.
// Assumes a 25 MHz reference clock; included by the package.
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

// Clock and time bases
`define TCS_CLK_HZ 25000000
`define TCS_MS_PER_S 1000
`define TCS_TONE_LO_HZ 1000
`define TCS_TONE_HI_HZ 2000
`define TCS_CLICK_SHORT_MS 5'd10
`define TCS_CLICK_LONG_MS 5'd20
`define TCS_CAL_UNITS_LOG2 6

// Register offsets
`define TCS_REG_THR 8'h04
`define TCS_REG_SND 8'h07
`define TCS_REG_STK 8'h09
`define TCS_REG_VER 8'h0B

// Field positions of the sounder configuration
`define TCS_SND_LEN_BIT 2
`define TCS_SND_TONE_BIT 1
`define TCS_SND_EN_BIT 0

// Reset values and limits
`define TCS_THR_RST 8'h00
`define TCS_SND_RST 3'h0
`define TCS_STK_RST 8'h00
`define TCS_THR_MAX 8'h3F
`define TCS_THR_STEP 16'h0004
`define TCS_VER_LAST 5'h1F

// Sizes and bus address
`define TCS_MEAS_W 16
`define TCS_NUM_EL 8
`define TCS_I2C_ADDR 7'h2A

`endif

/* tcs_i2c_host.sv */
// Behavioural I2C host that drives the register bus of the block.
// Assumes an open-drain SDA with a pull-up; the device side pulls low
// through its output enable.
`timescale 1ns/1ps
module tcs_i2c_host (
  input wire logic i_ref_clk,
  input wire logic i_dev_oe,
  output logic o_scl,
  output logic o_sda
);
  logic rel = 1'b1;
  int hp = 3;

  // Wired-AND bus level, pull-up when both release
  assign o_sda = rel & ~i_dev_oe;

  initial o_scl = 1'b1;

  // Wait whole cycles, changes land after the falling edge
  task automatic wt(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // One bit: data set in the low phase, sampled in the high phase
  task automatic bitx(input logic b, output logic r);
    wt(1);
    rel = b;
    wt(hp);
    o_scl = 1'b1;
    wt(hp);
    r = o_sda;
    wt(hp);
    o_scl = 1'b0;
  endtask

  // Start, also used as repeated start
  task automatic start();
    wt(1);
    rel = 1'b1;
    wt(hp);
    o_scl = 1'b1;
    wt(hp);
    rel = 1'b0;
    wt(hp);
    o_scl = 1'b0;
  endtask

  // Stop leaves both lines released
  task automatic stop();
    wt(1);
    rel = 1'b0;
    wt(hp);
    o_scl = 1'b1;
    wt(hp);
    rel = 1'b1;
    wt(hp);
  endtask

  // Byte out MSB first, then the ninth bit (host ACK/NACK or release)
  task automatic xfer(input logic [7:0] d, input logic nb,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(nb, r);
    ack = ~r;
  endtask
endmodule // tcs_i2c_host

/* tcs_pkg.sv */
// Types of the touch calibration and key-click block.
// Assumes tcs_defines.svh is on the include path.
package tcs_pkg;
  `include "tcs_defines.svh"

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_AACK = 3'b010,
    I2C_WR   = 3'b011,
    I2C_WACK = 3'b100,
    I2C_RD   = 3'b101,
    I2C_RACK = 3'b110
  } tcs_i2c_st_type;

  // Version text; the contents are arbitrary
  localparam logic [247:0] TCS_VER_STR = "ACME,PN:TCS1,QUAL:ENG,VER:1_0_0";

  typedef struct packed {
    tcs_i2c_st_type st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic ptr_ok;
    logic [7:0] ptr;
    logic [4:0] sidx;
    logic sda_oe;
    logic sda_o;
    logic [7:0] thr;
    logic [2:0] snd;
    logic [7:0] stuck_timeout_factor;
    logic [15:0] ms_cnt;
    logic [15:0] unit_cnt;
    logic [5:0] cal_cnt;
    logic [14:0] stk_cnt;
    logic ms_p;
    logic unit_p;
    logic p_vld;
    logic [2:0] p_ch;
    logic [`TCS_MEAS_W-1:0] p_val;
    logic [`TCS_NUM_EL-1:0] seeded;
    logic [`TCS_NUM_EL-1:0] touched;
    logic [`TCS_NUM_EL-1:0] cal_pend;
    logic [`TCS_NUM_EL-1:0] fold;
    logic click;
  } tcs_top_st_type;

  typedef struct packed {
    logic act;
    logic hi;
    logic [4:0] ms_left;
    logic [15:0] ph;
    logic out;
  } tcs_click_st_type;
endpackage

/* tcs_touch_cal.sv */
// Touch baseline calibration, stuck-key handling, key click and
// an I2C register slave. Assumes measurements are synchronous,
// arrive at most every second cycle, and SCL/SDA are sampled.
`timescale 1ns/1ps
`include "tcs_defines.svh"
module tcs_touch_cal import tcs_pkg::*; #(
  parameter logic [15:0] P_MS_CYC = 16'(`TCS_CLK_HZ / `TCS_MS_PER_S),
  parameter logic [15:0] P_HALF_LO =
    16'(`TCS_CLK_HZ / (2 * `TCS_TONE_LO_HZ)),
  parameter logic [15:0] P_HALF_HI =
    16'(`TCS_CLK_HZ / (2 * `TCS_TONE_HI_HZ)),
  parameter logic [6:0] P_I2C_ADDR = `TCS_I2C_ADDR
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_meas_valid,
  input wire logic [2:0] i_meas_chan,
  input wire logic [`TCS_MEAS_W-1:0] i_meas_value,
  input wire logic i_auto_recal_enable,
  input wire logic [7:0] i_base_tick_period,
  input wire logic [7:0] i_sample_interval_factor,
  output logic [`TCS_NUM_EL-1:0] o_touched,
  output logic o_sounder
);
  tcs_top_st_type st_ff, nxt_st;
  logic start_c, stop_c, rise_c, fall_c;
  logic [7:0] rd_byte;
  logic wr_stb;
  logic [`TCS_MEAS_W-1:0] base_rd, diff, thr_amt;
  logic [15:0] unit_len, unit_m1;
  logic [14:0] stk_lim;
  logic over;
  logic mem_we;
  logic snd_out;

  // Bus conditions from sampled SCL and SDA
  assign start_c = i_scl & st_ff.scl_q & st_ff.sda_q & ~i_sda;
  assign stop_c = i_scl & st_ff.scl_q & ~st_ff.sda_q & i_sda;
  assign rise_c = i_scl & ~st_ff.scl_q;
  assign fall_c = ~i_scl & st_ff.scl_q;
  assign wr_stb = (st_ff.st == I2C_WR) && fall_c && !start_c
                  && !stop_c && st_ff.bitc == 4'h8 && st_ff.ptr_ok;

  // Read data; version text walks one character per byte read
  always_comb begin
    case (st_ff.ptr)
      `TCS_REG_THR: rd_byte = st_ff.thr;
      `TCS_REG_SND: rd_byte = {5'h00, st_ff.snd};
      `TCS_REG_STK: rd_byte = st_ff.stuck_timeout_factor;
      `TCS_REG_VER: begin
        if (st_ff.sidx == `TCS_VER_LAST) begin
          rd_byte = 8'h00;
        end else begin
          rd_byte = TCS_VER_STR[(9'd247 - {1'b0, st_ff.sidx, 3'b000}) -: 8];
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Touch decision against the stored baseline
  assign diff = (base_rd >= st_ff.p_val) ? base_rd - st_ff.p_val
                                         : st_ff.p_val - base_rd;
  assign thr_amt = 16'(({8'h00, st_ff.thr} + 16'h0001) *
                       `TCS_THR_STEP);
  assign over = diff > thr_amt;

  // Time units: one unit is tick period times sample factor
  assign unit_len = 16'(i_base_tick_period) * 16'(i_sample_interval_factor);
  assign unit_m1 = (unit_len == 16'h0000) ? 16'h0000
                                          : unit_len - 16'h0001;
  assign stk_lim = 15'({1'b0, st_ff.stuck_timeout_factor} + 9'h001)
                   << `TCS_CAL_UNITS_LOG2;

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    mem_we = 1'b0;
    nxt_st.scl_q = i_scl;
    nxt_st.sda_q = i_sda;
    nxt_st.sda_o = 1'b0;
    // Serial slave
    if (stop_c) begin
      nxt_st.st = I2C_IDLE;
      nxt_st.sda_oe = 1'b0;
    end else if (start_c) begin
      nxt_st.st = I2C_ADDR;
      nxt_st.bitc = 4'h0;
      nxt_st.sda_oe = 1'b0;
      nxt_st.ptr_ok = 1'b0;
    end else begin
      unique case (st_ff.st)
        I2C_IDLE: begin
        end
        I2C_ADDR, I2C_WR: begin
          if (rise_c) begin
            nxt_st.sh = {st_ff.sh[6:0], i_sda};
            nxt_st.bitc = st_ff.bitc + 4'h1;
          end else if (fall_c && st_ff.bitc == 4'h8) begin
            nxt_st.bitc = 4'h0;
            if (st_ff.st == I2C_ADDR) begin
              if (st_ff.sh[7:1] == P_I2C_ADDR) begin
                nxt_st.st = I2C_AACK;
                nxt_st.sda_oe = 1'b1;
                nxt_st.rw = st_ff.sh[0];
              end else begin
                nxt_st.st = I2C_IDLE;
              end
            end else begin
              nxt_st.st = I2C_WACK;
              nxt_st.sda_oe = 1'b1;
              if (!st_ff.ptr_ok) begin
                nxt_st.ptr = st_ff.sh;
                nxt_st.ptr_ok = 1'b1;
                nxt_st.sidx = 5'h00;
              end else if (st_ff.ptr != `TCS_REG_VER) begin
                nxt_st.ptr = st_ff.ptr + 8'h01;
              end
            end
          end
        end
        I2C_AACK: begin
          if (fall_c) begin
            if (st_ff.rw) begin
              nxt_st.st = I2C_RD;
              nxt_st.sh = rd_byte;
              nxt_st.sda_oe = ~rd_byte[7];
            end else begin
              nxt_st.st = I2C_WR;
              nxt_st.sda_oe = 1'b0;
            end
          end
        end
        I2C_WACK: begin
          if (fall_c) begin
            nxt_st.st = I2C_WR;
            nxt_st.sda_oe = 1'b0;
          end
        end
        I2C_RD: begin
          if (fall_c) begin
            if (st_ff.bitc == 4'h7) begin
              nxt_st.st = I2C_RACK;
              nxt_st.sda_oe = 1'b0;
              nxt_st.bitc = 4'h0;
              if (st_ff.ptr == `TCS_REG_VER) begin
                nxt_st.sidx = st_ff.sidx + 5'h01;
              end else begin
                nxt_st.ptr = st_ff.ptr + 8'h01;
              end
            end else begin
              nxt_st.sh = {st_ff.sh[6:0], 1'b0};
              nxt_st.sda_oe = ~st_ff.sh[6];
              nxt_st.bitc = st_ff.bitc + 4'h1;
            end
          end
        end
        I2C_RACK: begin
          if (rise_c) begin
            nxt_st.nack = i_sda;
          end else if (fall_c) begin
            if (st_ff.nack) begin
              nxt_st.st = I2C_IDLE;
            end else begin
              nxt_st.st = I2C_RD;
              nxt_st.sh = rd_byte;
              nxt_st.sda_oe = ~rd_byte[7];
            end
          end
        end
        default: nxt_st.st = I2C_IDLE;
      endcase
    end
    // Register writes; the version register takes none
    if (wr_stb) begin
      case (st_ff.ptr)
        `TCS_REG_THR: nxt_st.thr = (st_ff.sh > `TCS_THR_MAX) ?
                                   `TCS_THR_MAX : st_ff.sh;
        `TCS_REG_SND: nxt_st.snd = st_ff.sh[2:0];
        `TCS_REG_STK: nxt_st.stuck_timeout_factor = st_ff.sh;
        default: begin
        end
      endcase
    end
    // Millisecond and unit time base
    nxt_st.ms_p = 1'b0;
    nxt_st.unit_p = 1'b0;
    if (st_ff.ms_cnt >= P_MS_CYC - 16'h0001) begin
      nxt_st.ms_cnt = 16'h0000;
      nxt_st.ms_p = 1'b1;
    end else begin
      nxt_st.ms_cnt = st_ff.ms_cnt + 16'h0001;
    end
    if (st_ff.ms_p) begin
      if (st_ff.unit_cnt >= unit_m1) begin
        nxt_st.unit_cnt = 16'h0000;
        nxt_st.unit_p = 1'b1;
      end else begin
        nxt_st.unit_cnt = st_ff.unit_cnt + 16'h0001;
      end
    end
    // Periodic calibration every 64 units
    if (st_ff.unit_p) begin
      nxt_st.cal_cnt = st_ff.cal_cnt + 6'h01;
      if (st_ff.cal_cnt == 6'h3F && i_auto_recal_enable
          && st_ff.touched == '0) begin
        nxt_st.cal_pend = '1;
      end
    end
    if (st_ff.touched != '0) begin
      nxt_st.cal_pend = '0;
    end
    // Stuck touch timer over 64 units per factor step
    if (st_ff.touched == '0 || st_ff.stuck_timeout_factor == 8'h00) begin
      nxt_st.stk_cnt = 15'h0000;
    end else if (st_ff.unit_p) begin
      if (st_ff.stk_cnt == stk_lim - 15'h0001) begin
        nxt_st.stk_cnt = 15'h0000;
        nxt_st.fold = st_ff.touched;
      end else begin
        nxt_st.stk_cnt = st_ff.stk_cnt + 15'h0001;
      end
    end
    // Measurement pipeline, baseline read one cycle earlier
    nxt_st.p_vld = i_meas_valid;
    nxt_st.p_ch = i_meas_chan;
    nxt_st.p_val = i_meas_value;
    nxt_st.click = 1'b0;
    if (st_ff.p_vld) begin
      if (!st_ff.seeded[st_ff.p_ch]) begin
        mem_we = 1'b1;
        nxt_st.seeded[st_ff.p_ch] = 1'b1;
        nxt_st.touched[st_ff.p_ch] = 1'b0;
      end else if (st_ff.fold[st_ff.p_ch]) begin
        mem_we = 1'b1;
        nxt_st.fold[st_ff.p_ch] = 1'b0;
        nxt_st.touched[st_ff.p_ch] = 1'b0;
      end else if (st_ff.cal_pend[st_ff.p_ch] && st_ff.touched == '0) begin
        mem_we = 1'b1;
        nxt_st.cal_pend[st_ff.p_ch] = 1'b0;
      end else begin
        nxt_st.touched[st_ff.p_ch] = over;
        nxt_st.click = over && !st_ff.touched[st_ff.p_ch];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_ff <= '0;
      // Line samples start at the idle bus level, no false edge
      st_ff.scl_q <= 1'b1;
      st_ff.sda_q <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  tcs_base_mem #(
    .W(`TCS_MEAS_W),
    .DEPTH(`TCS_NUM_EL),
    .AW(3)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_we(mem_we),
    .i_waddr(st_ff.p_ch),
    .i_wdata(st_ff.p_val),
    .i_raddr(i_meas_chan),
    .o_rdata(base_rd)
  );

  // Sounder runs only from touch events, not from bus state
  tcs_click_gen #(
    .P_HALF_LO(P_HALF_LO),
    .P_HALF_HI(P_HALF_HI)
  ) u_click (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_start(st_ff.click),
    .i_ms_p(st_ff.ms_p),
    .i_enable(st_ff.snd[`TCS_SND_EN_BIT]),
    .i_long(st_ff.snd[`TCS_SND_LEN_BIT]),
    .i_high(st_ff.snd[`TCS_SND_TONE_BIT]),
    .o_sound(snd_out)
  );

  assign o_sda = st_ff.sda_o;
  assign o_sda_oe = st_ff.sda_oe;
  assign o_touched = st_ff.touched;
  assign o_sounder = snd_out;

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_decide;
    st_ff.p_vld && st_ff.seeded[st_ff.p_ch] && !st_ff.fold[st_ff.p_ch]
      && !(st_ff.cal_pend[st_ff.p_ch] && st_ff.touched == '0);
  endsequence
  sequence s_new_touch;
    s_decide and (over && !st_ff.touched[st_ff.p_ch]);
  endsequence

  a_first_base: assert property (
    st_ff.p_vld && !st_ff.seeded[st_ff.p_ch]
      |-> mem_we ##1 st_ff.seeded[$past(st_ff.p_ch)])
    else $error("first measurement not stored");
  a_diff_decide: assert property (
    s_decide |=> st_ff.touched[$past(st_ff.p_ch)] == $past(over))
    else $error("touch decision mismatch");
  a_click_start: assert property (
    s_new_touch ##1 (st_ff.click && st_ff.snd[`TCS_SND_EN_BIT]
      && $stable(st_ff.snd)) |=> o_sounder)
    else $error("new touch gave no click");
  a_cal_enable: assert property (
    st_ff.cal_pend == '0 ##1 st_ff.cal_pend != '0
      |-> $past(i_auto_recal_enable))
    else $error("calibration while disabled");
  a_cal_period: assert property (
    st_ff.cal_pend == '0 ##1 st_ff.cal_pend != '0
      |-> $past(st_ff.unit_p) && $past(st_ff.cal_cnt) == 6'h3F)
    else $error("calibration off period");
  a_cal_skip: assert property (
    st_ff.touched != '0 && st_ff.p_vld && st_ff.seeded[st_ff.p_ch]
      && !st_ff.fold[st_ff.p_ch] |-> !mem_we)
    else $error("baseline changed during touch");
  a_stuck_fold: assert property (
    st_ff.p_vld && st_ff.seeded[st_ff.p_ch] && st_ff.fold[st_ff.p_ch]
      |-> mem_we ##1 !st_ff.touched[$past(st_ff.p_ch)])
    else $error("stuck touch not folded");
  a_stuck_time: assert property (
    st_ff.fold == '0 ##1 st_ff.fold != '0
      |-> $past(st_ff.unit_p) && $past(st_ff.stk_cnt) ==
          $past(stk_lim) - 15'h0001)
    else $error("stuck timeout wrong");
  a_stuck_off: assert property (
    st_ff.stuck_timeout_factor == 8'h00 && st_ff.fold == '0 |=> st_ff.fold == '0)
    else $error("stuck fold while disabled");
  a_thr_store: assert property (
    wr_stb && st_ff.ptr == `TCS_REG_THR && st_ff.sh <= `TCS_THR_MAX
      |=> st_ff.thr == $past(st_ff.sh))
    else $error("threshold not stored");
  a_thr_clamp: assert property (
    wr_stb && st_ff.ptr == `TCS_REG_THR && st_ff.sh > `TCS_THR_MAX
      |=> st_ff.thr == `TCS_THR_MAX)
    else $error("threshold not clamped");
  a_ver_nul: assert property (
    st_ff.ptr == `TCS_REG_VER && st_ff.sidx == `TCS_VER_LAST
      |-> rd_byte == 8'h00)
    else $error("version text not terminated");
endmodule // tcs_touch_cal

/* tcs_touch_cal_tb.sv */
// Self-checking bench of the touch calibration and key-click block.
// Assumes the host model in tcs_i2c_host.sv and shortened timers.
`timescale 1ns/1ps
module tcs_touch_cal_tb import tcs_pkg::*; ;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic meas_v = 1'b0;
  logic auto_en = 1'b0;
  logic [2:0] ch = 3'h0;
  logic [15:0] mv = 16'h0000;
  logic [15:0] base [8];
  logic [15:0] amt;
  logic [7:0] thr;
  logic [7:0] v;
  logic [7:0] tick = 8'h01;
  logic [7:0] spf = 8'h01;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 70;
  int first, last, run, half, nms;
  wire scl, sda, sda_o, sda_oe, snd;
  wire [7:0] tch;

  // Clock, 40 ns period
  always #20 i_ref_clk = ~i_ref_clk;

  tcs_i2c_host host (.i_ref_clk(i_ref_clk), .i_dev_oe(sda_oe),
    .o_scl(scl), .o_sda(sda));

  tcs_touch_cal #(.P_MS_CYC(16'h0010), .P_HALF_LO(16'h0004),
    .P_HALF_HI(16'h0002)) uut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .i_meas_valid(meas_v), .i_meas_chan(ch), .i_meas_value(mv),
    .i_auto_recal_enable(auto_en), .i_base_tick_period(tick),
    .i_sample_interval_factor(spf), .o_touched(tch), .o_sounder(snd));

  // Compare and count
  task automatic check(input logic [15:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Expected version character at a burst index
  function automatic logic [7:0] vchar(input int i);
    return (i < 31) ? TCS_VER_STR[247 - 8*i -: 8] : 8'h00;
  endfunction

  // Expected stored threshold
  function automatic logic [7:0] clamp(input logic [7:0] x);
    return (x > 8'h3F) ? 8'h3F : x;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic reset();
    i_srst = 1'b1;
    auto_en = 1'b0;
    cyc(6);
    i_srst = 1'b0;
  endtask

  // Register write: address, pointer, one data byte
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    logic k;
    host.start();
    host.xfer(8'h54, 1'b1, q, k);
    host.xfer(a, 1'b1, q, k);
    host.xfer(d, 1'b1, q, k);
    check(k, 1'b1, "write ack");
    host.stop();
  endtask

  // Burst read of n bytes with each byte compared
  task automatic rdchk(input logic [7:0] a, input int n, input logic [7:0] e);
    logic [7:0] q;
    logic k;
    host.start();
    host.xfer(8'h54, 1'b1, q, k);
    host.xfer(a, 1'b1, q, k);
    host.start();
    host.xfer(8'h55, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hFF, i == n - 1, q, k);
      check(q, (a == 8'h0B) ? vchar(i) : e, "read data");
    end
    host.stop();
  endtask

  // One measurement, touch state compared once it has landed
  task automatic meas(input logic [2:0] c, input logic [15:0] x,
                      input logic e);
    cyc(1);
    meas_v = 1'b1;
    ch = c;
    mv = x;
    cyc(1);
    meas_v = 1'b0;
    cyc(2);
    check(tch[c], e, "touch state");
  endtask

  // Hang guard
  initial begin
    cyc(60000);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    reset();
    check(tch, 8'h00, "touch after reset");
    check(sda_oe, 1'b0, "sda after reset");
    check(sda_o, 1'b0, "sda level");
    wr(8'h0B, 8'h55);
    rdchk(8'h0B, 32, 8'h00);
    // Threshold writes: corners then random, bus speed varied
    for (int k = 0; k < 6; k++) begin
      host.hp = 2 + k % 3;
      v = (k == 0) ? 8'h3F : (k == 1) ? 8'h40 : 8'($random(seed));
      wr(8'h04, v);
      rdchk(8'h04, 1, clamp(v));
    end
    thr = 8'($random(seed)) & 8'h3F;
    wr(8'h04, thr);
    amt = 16'((thr + 1) * 4);
    // Seed, edge of the threshold, below baseline, release
    for (int c = 0; c < 8; c++) begin
      base[c] = 16'h2010 + (16'($random(seed)) & 16'h3FFF);
      meas(3'(c), base[c], 1'b0);
      meas(3'(c), base[c] + amt, 1'b0);
      meas(3'(c), base[c] - amt, 1'b0);
      meas(3'(c), base[c] + amt + 16'h0001, 1'b1);
      meas(3'(c), base[c] - amt - 16'h0001, 1'b1);
      meas(3'(c), base[c], 1'b0);
    end
    // Stuck detection off keeps a long touch
    meas(0, base[0] + amt + 16'h0001, 1'b1);
    cyc(2500);
    meas(0, base[0] + amt + 16'h0001, 1'b1);
    meas(0, base[0], 1'b0);
    // Auto calibration off, then on while touched, then on while idle
    cyc(1100);
    meas(1, base[1] + amt + 16'h0001, 1'b1);
    auto_en = 1'b1;
    cyc(1100);
    meas(1, base[1] + amt + 16'h0001, 1'b1);
    meas(1, base[1], 1'b0);
    cyc(1100);
    meas(1, base[1] + amt + 16'h0001, 1'b0);
    meas(1, base[1] + amt + 16'h0001, 1'b0);
    // New reset reseeds; stuck factor code 1 is factor 2
    reset();
    spf = 8'h02;
    meas(3, base[3] + 16'h0100, 1'b0);
    wr(8'h09, 8'h01);
    meas(3, base[3] + 16'h0200, 1'b1);
    cyc(3900);
    meas(3, base[3] + 16'h0200, 1'b1);
    cyc(300);
    meas(3, base[3] + 16'h0200, 1'b0);
    meas(3, base[3] + 16'h0200, 1'b0);
    wr(8'h09, 8'h00);
    spf = 8'h01;
    // Every sounder setting, one click per new touch, bus idle
    meas(5, base[5], 1'b0);
    for (int s = 0; s < 8; s++) begin
      wr(8'h07, 8'(s));
      meas(5, base[5] + 16'h0100, 1'b1);
      first = -1;
      last = -1;
      run = 0;
      for (int t = 0; t < 400; t++) begin
        if (snd === 1'b1) begin
          if (first < 0) first = t;
          if (t == first + run) run++;
          last = t;
        end
        cyc(1);
      end
      half = s[1] ? 2 : 4;
      nms = s[2] ? 20 : 10;
      if (s[0] == 1'b0) begin
        check(first < 0, 1'b1, "sounder gated");
      end else begin
        check(first >= 0 && first <= 2, 1'b1, "click start");
        check(16'(run), 16'(half), "tone half period");
        check(last + 1 - first >= (nms - 1) * 16 - 8 &&
          last + 1 - first <= nms * 16 + 8, 1'b1, "click length");
      end
      meas(5, base[5], 1'b0);
    end
    conclude();
  end
endmodule // tcs_touch_cal_tb
